// ---- ees_buf2.v ----
// small valid/ready buffer in the write data path
`timescale 1ns/100ps
module ees_buf2 #(
	parameter WIDTH = 12,
	parameter DEPTH = 2,
	parameter PTR_W = 1
)(
	// clock and reset
	input  wire             clk,
	input  wire             srst,
	// filling side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// draining side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [PTR_W-1:0] wp_r;
	reg [PTR_W-1:0] rp_r;
	reg [PTR_W:0]   cnt_r;
	wire            push;
	wire            pop;

	// honest flags straight from the fill count
	assign in_ready  = (cnt_r != DEPTH[PTR_W:0]);
	assign out_valid = (cnt_r != {(PTR_W+1){1'b0}});
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// =====================================================
	// pointers and storage
	always @(posedge clk)
	begin
		if (srst)
		begin
			wp_r  <= {PTR_W{1'b0}};
			rp_r  <= {PTR_W{1'b0}};
			cnt_r <= {(PTR_W+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_r[wp_r] <= in_data;
				wp_r        <= (wp_r == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wp_r + 1'b1;
			end
			if (pop)
				rp_r <= (rp_r == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rp_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// ---- ees_map.vh ----
// constants of the two-wire eeprom slave front end
`ifndef EES_MAP_VH
`define EES_MAP_VH

// internal programming time and clock rate
`define EES_PROG_TIME_US  5000
`define EES_CLK_MHZ       200

// array and page geometry
`define EES_ADDR_W        8
`define EES_OFFS_W        4
`define EES_PAGE_BYTES    16
`define EES_DATA_W        8

// bit positions inside the device address word
`define EES_AW_RW         0
`define EES_AW_SEL_LO     1
`define EES_AW_SEL_HI     3
`define EES_AW_TYPE_LO    4
`define EES_AW_TYPE_HI    7

// bit counts of one transfer and the programming timer width
`define EES_LAST_BIT      3'h7
`define EES_TX_DONE       4'h8
`define EES_TMR_W         24

`endif

// ---- ees_master_model.sv ----
// bus master model: drives the serial clock and pulls the data wire
`timescale 1ns/100ps
module ees_master (
	// serial link
	output reg  scl,
	output reg  m_oe,
	input  wire sda
);
	integer q = 40;
	reg     s;
	// clock stands high and data released between frames
	initial
	begin
		scl = 1'b1;
		m_oe = 1'b0;
	end
	// one bit: data moves mid low phase, sampled mid high phase
	task put(input b, output r);
	begin
		#q m_oe = !b;
		#q scl = 1'b1;
		#q r = sda;
		#q scl = 1'b0;
	end
	endtask
	// start works from idle or as a repeated start
	task start;
	begin
		#q m_oe = 1'b0;
		#q scl = 1'b1;
		#q m_oe = 1'b1;
		#q scl = 1'b0;
	end
	endtask
	task stop;
	begin
		#q m_oe = 1'b1;
		#q scl = 1'b1;
		#q m_oe = 1'b0;
		#q;
	end
	endtask
	// byte out msb first, then release for the acknowledge
	task wb(input [7:0] d, output a);
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
			put(d[i], s);
		put(1'b1, a);
	end
	endtask
	// byte in, then acknowledge low or leave high to end
	task rb(input na, output [7:0] d);
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
			put(1'b1, d[i]);
		put(na, s);
	end
	endtask
endmodule

// ---- ees_slave.v ----
// two-wire serial eeprom slave: protocol engine, page buffer, array
`timescale 1ns/100ps
`include "ees_map.vh"

// Notes on behaviour
// - sample on clock rise, drive after fall
// - start is data falling, clock high
// - stop is data rising; read returns idle
// - stop after write starts programming cycle
// - eight bits then one acknowledge clock
// - read: ack address, send bytes while acked
// - nack plus stop ends the read
// - no ack nor stop: stay released
// - address word: type, select, direction
// - respond only when select matches straps
// - direction zero writes, one reads
// - byte write: address, memory address, data
// - while programming only nack the polls
// - more bytes make a page write
// - page writes wrap low four bits
// - protect pin high: nack data, no programming
// - protected page write refused at first byte
// - protect low writes all; reads always
// - poll with write word: nack while busy
// - programming ends within five milliseconds
// - dummy write sets address for reading
// - sequential read wraps whole array
module ees_slave #(
	parameter [3:0] DEV_TYPE    = 4'h6,   // type code, value is arbitrary
	parameter       PROG_CYCLES = `EES_PROG_TIME_US * `EES_CLK_MHZ
)(
	// clock and reset
	REF_CLK,
	SRST,
	// serial link pins
	SCL,
	SDA_IN,
	SDA_OUT,
	SDA_OE,
	// straps and status
	CHIP_SELECT_STRAPS,
	WP,
	BUSY
);
	input  wire       REF_CLK;
	input  wire       SRST;
	input  wire       SCL;
	input  wire       SDA_IN;
	output reg        SDA_OUT;
	output reg        SDA_OE;
	input  wire [2:0] CHIP_SELECT_STRAPS;
	input  wire       WP;
	output reg        BUSY;

	localparam S_IDLE = 3'h0;
	localparam S_DEV  = 3'h1;
	localparam S_ACK  = 3'h2;
	localparam S_MADR = 3'h3;
	localparam S_WDAT = 3'h4;
	localparam S_TX   = 3'h5;
	localparam S_MACK = 3'h6;
	localparam S_HOLD = 3'h7;

	// cut on purpose: the programming count always fits the timer width
	localparam integer          PROG_LAST = PROG_CYCLES - 1;
	localparam [`EES_TMR_W-1:0] TMR_LAST  = PROG_LAST[`EES_TMR_W-1:0];

	// =====================================================
	// pin synchronisers and edge detection
	wire [5:0] pins_s;
	wire       scl_s;
	wire       sda_s;
	wire       wp_s;
	wire [2:0] sel_s;
	reg        scl_q;
	reg        sda_q;

	ees_sync #(
		.WIDTH (6)
	) u_sync (
		.clk  (REF_CLK),
		.srst (SRST),
		.d    ({CHIP_SELECT_STRAPS, WP, SDA_IN, SCL}),
		.q    (pins_s)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign wp_s  = pins_s[2];
	assign sel_s = pins_s[5:3];

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

	// =====================================================
	// state of the protocol engine
	reg [2:0]                st_r;
	reg [2:0]                after_r;
	reg [2:0]                bit_r;
	reg [3:0]                tcnt_r;
	reg [7:0]                sh_r;
	reg [7:0]                tx_r;
	reg                      ack_r;
	reg                      aph_r;
	reg [`EES_ADDR_W-1:0]    addr_r;
	reg                      wr_any_r;
	reg [`EES_TMR_W-1:0]     tmr_r;
	reg [`EES_DATA_W-1:0]    mem_r [0:(1<<`EES_ADDR_W)-1];

	wire [7:0] rx_byte  = {sh_r[6:0], sda_s};
	wire       byte_end = scl_rise & (bit_r == `EES_LAST_BIT);
	wire [7:0] rd_byte  = mem_r[addr_r];
	// straps are pulled low on the board side when left open
	wire       sel_hit  = (rx_byte[`EES_AW_SEL_HI:`EES_AW_SEL_LO] == sel_s) &
	                      (rx_byte[`EES_AW_TYPE_HI:`EES_AW_TYPE_LO] == DEV_TYPE);
	wire       commit   = BUSY & (tmr_r == TMR_LAST);

	// =====================================================
	// write path buffer between receiver and page buffer
	wire                   buf_in_ready;
	wire                   buf_out_valid;
	wire [11:0]            buf_out_data;
	wire                   buf_push = (st_r == S_WDAT) & byte_end & ~wp_s & ~BUSY;
	wire                   buf_pop  = buf_out_valid & ~commit;
	// draining stalls in the commit cycle so no byte races the array copy

	ees_buf2 #(
		.WIDTH (12),
		.DEPTH (2),
		.PTR_W (1)
	) u_buf (
		.clk       (REF_CLK),
		.srst      (SRST),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.in_data   ({addr_r[`EES_OFFS_W-1:0], rx_byte}),
		.out_valid (buf_out_valid),
		.out_ready (~commit),
		.out_data  (buf_out_data)
	);

	// =====================================================
	// page buffer, one entry per byte of the page
	wire [`EES_PAGE_BYTES*8-1:0] pbuf_w;
	wire [`EES_PAGE_BYTES-1:0]   pval_w;

	genvar g;
	generate
		for (g = 0; g < `EES_PAGE_BYTES; g = g + 1)
		begin : gp
			reg [7:0] byte_r;
			reg       val_r;
			// later bytes at the same offset overwrite earlier ones
			always @(posedge REF_CLK)
			begin
				if (SRST)
				begin
					byte_r <= 8'h00;
					val_r  <= 1'b0;
				end
				else if (commit)
					val_r <= 1'b0;
				else if (buf_pop && buf_out_data[11:8] == g)
				begin
					byte_r <= buf_out_data[7:0];
					val_r  <= 1'b1;
				end
			end
			assign pbuf_w[g*8 +: 8] = byte_r;
			assign pval_w[g]        = val_r;
		end
	endgenerate

	// =====================================================
	// array commit at the end of the programming time
	// every page entry marked valid lands in one cycle, as one internal write
	integer i;
	always @(posedge REF_CLK)
	begin
		if (commit)
			for (i = 0; i < `EES_PAGE_BYTES; i = i + 1)
				if (pval_w[i])
					mem_r[{addr_r[`EES_ADDR_W-1:`EES_OFFS_W], i[3:0]}] <= pbuf_w[i*8 +: 8];
	end

	// =====================================================
	// programming timer
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			BUSY  <= 1'b0;
			tmr_r <= {`EES_TMR_W{1'b0}};
		end
		else if (BUSY)
		begin
			tmr_r <= tmr_r + 1'b1;
			if (commit)
				BUSY <= 1'b0;
		end
		else if (stop_c && wr_any_r)
		begin
			BUSY  <= 1'b1;
			tmr_r <= {`EES_TMR_W{1'b0}};
		end
	end

	// =====================================================
	// protocol engine: bits in on rise, drive on fall
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			st_r     <= S_IDLE;
			after_r  <= S_IDLE;
			bit_r    <= 3'h0;
			tcnt_r   <= 4'h0;
			sh_r     <= 8'h00;
			tx_r     <= 8'h00;
			ack_r    <= 1'b0;
			aph_r    <= 1'b0;
			addr_r   <= {`EES_ADDR_W{1'b0}};
			wr_any_r <= 1'b0;
			SDA_OUT  <= 1'b0;
			SDA_OE   <= 1'b0;
		end
		else
		begin
			scl_q   <= scl_s;
			sda_q   <= sda_s;
			SDA_OUT <= 1'b0;   // open drain: only ever pulls low
			if (commit)
				wr_any_r <= 1'b0;
			if (stop_c)
			begin
				SDA_OE <= 1'b0;
				st_r   <= S_IDLE;
			end
			else if (start_c)
			begin
				SDA_OE <= 1'b0;
				st_r   <= S_DEV;
				bit_r  <= 3'h0;
				if (!BUSY)
					wr_any_r <= 1'b0;
			end
			else
			begin
				case (st_r)
				S_DEV, S_MADR, S_WDAT:
				begin
					if (scl_rise)
					begin
						sh_r  <= rx_byte;
						bit_r <= bit_r + 1'b1;
					end
					if (byte_end)
					begin
						aph_r <= 1'b0;
						st_r  <= S_ACK;
						if (st_r == S_DEV)
						begin
							if (!sel_hit)
								st_r <= S_IDLE;
							else if (BUSY)
							begin
								ack_r   <= 1'b0;
								after_r <= S_HOLD;
							end
							else
							begin
								ack_r   <= 1'b1;
								after_r <= rx_byte[`EES_AW_RW] ? S_TX : S_MADR;
							end
						end
						else if (st_r == S_MADR)
						begin
							addr_r  <= rx_byte;
							ack_r   <= 1'b1;
							after_r <= S_WDAT;
						end
						else if (wp_s || !buf_in_ready || BUSY)
						begin
							ack_r   <= 1'b0;
							after_r <= S_HOLD;
						end
						else
						begin
							ack_r    <= 1'b1;
							after_r  <= S_WDAT;
							wr_any_r <= 1'b1;
							addr_r   <= {addr_r[`EES_ADDR_W-1:`EES_OFFS_W],
							             addr_r[`EES_OFFS_W-1:0] + 1'b1};
						end
					end
				end
				S_ACK:
				begin
					if (scl_fall && !aph_r)
					begin
						SDA_OE <= ack_r;
						aph_r  <= 1'b1;
					end
					else if (scl_fall)
					begin
						st_r  <= after_r;
						bit_r <= 3'h0;
						if (after_r == S_TX)
						begin
							tx_r   <= rd_byte;
							SDA_OE <= ~rd_byte[7];
							tcnt_r <= 4'h0;
						end
						else
							SDA_OE <= 1'b0;
					end
				end
				S_TX:
				begin
					if (scl_rise)
						tcnt_r <= tcnt_r + 1'b1;
					if (scl_fall && tcnt_r == `EES_TX_DONE)
					begin
						SDA_OE <= 1'b0;
						addr_r <= addr_r + 1'b1;
						st_r   <= S_MACK;
					end
					else if (scl_fall)
					begin
						tx_r   <= {tx_r[6:0], 1'b0};
						SDA_OE <= ~tx_r[6];
					end
				end
				S_MACK:
				begin
					if (scl_rise && !sda_s)
					begin
						st_r    <= S_ACK;
						aph_r   <= 1'b1;
						after_r <= S_TX;
					end
					else if (scl_rise)
						st_r <= S_HOLD;
				end
				S_HOLD:
					SDA_OE <= 1'b0;
				default:
					SDA_OE <= 1'b0;
				endcase
			end
		end
	end
endmodule

// ---- ees_slave_monitor.sv ----
// port checker of the two-wire eeprom slave
`timescale 1ns/100ps
module ees_slave_monitor #(
	parameter PROG_CYCLES = 200
)(
	// clock and reset
	input wire       REF_CLK,
	input wire       SRST,
	// serial link pins
	input wire       SCL,
	input wire       SDA_IN,
	input wire       SDA_OUT,
	input wire       SDA_OE,
	// straps and status
	input wire [2:0] CHIP_SELECT_STRAPS,
	input wire       WP,
	input wire       BUSY
);
	reg [23:0] busy_cnt_r;
	reg [3:0]  stop_age_r;
	reg        scl_r;
	reg        sda_r;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	// busy length and stop age; age saturates so it never wraps
	always @(posedge REF_CLK)
	begin
		scl_r <= SCL;
		sda_r <= SDA_IN;
		busy_cnt_r <= (SRST | !BUSY) ? 24'h00_0000 : busy_cnt_r + 24'h00_0001;
		if (SRST | (SCL & scl_r & SDA_IN & !sda_r))
			stop_age_r <= 4'h0;
		else if (stop_age_r != 4'hf)
			stop_age_r <= stop_age_r + 4'h1;
	end
	// pin behaviour
	a_out_low: assert property (SDA_OUT == 1'b0)
		else $error("data output not low");
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL, 2))
		else $error("data drive moved with clock high");
	a_ack_holds: assert property ($rose(SDA_OE) |-> SDA_OE[*8])
		else $error("data drive too short");
	a_oe_bounded: assert property ($rose(SDA_OE) |-> ##[1:1000] !SDA_OE)
		else $error("data line never released");
	// programming cycle
	a_busy_len: assert property ($fell(BUSY) |-> busy_cnt_r == PROG_CYCLES)
		else $error("busy length wrong");
	a_busy_stop: assert property ($rose(BUSY) |-> stop_age_r < 4'h8)
		else $error("busy without stop");
	a_busy_quiet: assert property (BUSY |-> !SDA_OE)
		else $error("acknowledge while busy");
	a_wp_no_prog: assert property ($rose(BUSY) |-> !WP)
		else $error("programming while protected");
endmodule

bind ees_slave ees_slave_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_ees_slave_monitor (
	.REF_CLK(REF_CLK),
	.SRST(SRST),
	.SCL(SCL),
	.SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE),
	.CHIP_SELECT_STRAPS(CHIP_SELECT_STRAPS),
	.WP(WP),
	.BUSY(BUSY)
);

// ---- ees_slave_tb_top.sv ----
// self-checking bench of the two-wire eeprom slave
`timescale 1ns/100ps
module ees_slave_tb_top;
	localparam [3:0] TY = 4'h6; // type code, value is arbitrary
	// long enough that the first poll lands inside the programming cycle
	localparam       PROG = 400;
	reg        clk = 1'b0;
	reg        srst = 1'b1;
	reg        wp = 1'b0;
	reg  [2:0] cs = 3'h0;
	wire       scl;
	wire       m_oe;
	wire       oe;
	wire       busy;
	wire       sda = ~(oe | m_oe);
	reg  [7:0] mem [0:255];
	reg  [7:0] a;
	reg  [7:0] d;
	reg        k;
	integer    err_count = 0;
	integer    check_count = 0;
	integer    seed = 32'hc409_b2d0;
	integer    n;
	integer    rv;
	// clock and units
	always #2.5 clk = ~clk;
	ees_slave #(.DEV_TYPE(TY), .PROG_CYCLES(PROG)) i_ees_slave (.REF_CLK(clk), .SRST(srst),
		.SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe), .CHIP_SELECT_STRAPS(cs),
		.WP(wp), .BUSY(busy));
	ees_master i_ees_master (.scl(scl), .m_oe(m_oe), .sda(sda));
	// expected address word
	function [7:0] wd(input r);
		wd = {TY, cs, r};
	endfunction
	task cmp(input [7:0] g, input [7:0] e);
	begin
		check_count = check_count + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task cmp_ack(input g, input e);
		cmp({7'h00, g}, {7'h00, e});
	endtask
	task adr(input r, input e);
	begin
		i_ees_master.start;
		i_ees_master.wb(wd(r), k);
		cmp_ack(k, e);
	end
	endtask
	// write c bytes, then poll the programming cycle
	task wr(input [7:0] ad, input integer c);
		integer j;
	begin
		adr(1'b0, 1'b0);
		i_ees_master.wb(ad, k);
		cmp_ack(k, 1'b0);
		for (j = 0; j < c; j = j + 1)
		begin
			rv = $random(seed);
			d = rv[7:0];
			i_ees_master.wb(d, k);
			cmp_ack(k, wp);
			if (!wp)
				mem[{ad[7:4], ad[3:0] + j[3:0]}] = d;
		end
		i_ees_master.stop;
		cmp_ack(busy, !wp);
		adr(1'b0, !wp);
		i_ees_master.stop;
		adr(1'b0, 1'b0);
		cmp_ack(busy, 1'b0);
		i_ees_master.stop;
	end
	endtask
	// random read of c bytes, then one extra byte with the line left released
	task rd(input [7:0] ad, input integer c);
		integer j;
	begin
		adr(1'b0, 1'b0);
		i_ees_master.wb(ad, k);
		cmp_ack(k, 1'b0);
		adr(1'b1, 1'b0);
		for (j = 0; j < c; j = j + 1)
		begin
			i_ees_master.rb(j == c - 1, d);
			cmp(d, mem[ad + j[7:0]]);
		end
		i_ees_master.rb(1'b1, d);
		cmp(d, 8'hff);
		i_ees_master.stop;
	end
	endtask
	task finish_test;
	begin
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		#1 srst = 1'b0;
		rv = $random(seed);
		cs = rv[2:0];
		repeat (3) @(posedge clk);
		#1;
		wr(8'hf5, 16);
		wr(8'h0b, 18);
		rd(8'hf8, 16);
		for (n = 0; n < 3; n = n + 1)
		begin
			rv = $random(seed);
			a = rv[7:0];
			wr(a, 16 + n * 2);
			rd({a[7:4], 4'h0}, 16);
		end
		@(posedge clk);
		#1 wp = 1'b1;
		wr(a, 2);
		rd({a[7:4], 4'h0}, 2);
		for (n = 0; n < 2; n = n + 1)
		begin
			i_ees_master.start;
			i_ees_master.wb(n ? {TY, ~cs, 1'b1} : {~TY, cs, 1'b0}, k);
			cmp_ack(k, 1'b1);
			i_ees_master.stop;
		end
		finish_test;
	end
	// watchdog against a hung link
	initial
	begin
		#500_000;
		err_count = err_count + 1;
		finish_test;
	end
endmodule

// ---- ees_sync.v ----
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module ees_sync #(
	parameter WIDTH = 1
)(
	// clock and reset
	input  wire             clk,
	input  wire             srst,
	// asynchronous level in, synchronised level out
	input  wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// =====================================================
	// stages
	// first stage feeds only the second one
	always @(posedge clk)
	begin
		if (srst)
		begin
			meta_r <= {WIDTH{1'b1}};
			sync_r <= {WIDTH{1'b1}};
		end
		else
		begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule
